// ===== src/dmaarb_defines.svh
// Register map, field positions and reset values of the channel arbiter
`ifndef DMAARB_DEFINES_SVH
`define DMAARB_DEFINES_SVH
`define DMAARB_REG_CTRL     3'h0
`define DMAARB_REG_ECON     3'h1
`define DMAARB_REG_IRQ      3'h2
`define DMAARB_REG_SSA      3'h3
`define DMAARB_REG_DSA      3'h4
`define DMAARB_REG_SIZE     3'h5
`define DMAARB_REG_CSIZ     3'h6
`define DMAARB_REG_PTR      3'h7
`define DMAARB_CTRL_ON      7
`define DMAARB_CTRL_BUSY    15
`define DMAARB_ECON_ABT_EN  3
`define DMAARB_ECON_SEL_LSB 16
`define DMAARB_IRQ_EN_LSB   16
`define DMAARB_F_ERR        0
`define DMAARB_F_ABORT      1
`define DMAARB_F_CELL       2
`define DMAARB_F_BLOCK      3
`define DMAARB_F_DHALF      4
`define DMAARB_F_DEND       5
`define DMAARB_F_SHALF      6
`define DMAARB_F_SEND       7
`define DMAARB_RR_RESET     3'h7
`endif

// ===== src/dmaarb_pkg.sv
// Types shared by the channel arbiter
package dmaarb_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b10
  } dmaarb_state_t;
endpackage : dmaarb_pkg

// ===== src/dmaarb_top.sv
// Eight-channel DMA arbiter, byte-aligning mover and per-channel flags
// Notes on behaviour
// - Eight channels 0..7, each with its own interrupt request output.
// - Natural priority: channel 0 highest after reset, then the channel after the last winner.
// - Two-bit priority in control bits 1:0; 3 highest, 0 lowest.
// - Equal programmed priority starts from channel 0 after reset, then rotates.
// - Highest pending priority is served before any lower priority.
// - Equal top-priority channels rotate, one transaction each.
// - A running transaction always finishes before a new grant.
// - Read takes the bytes left in the addressed word.
// - Near source end only the remaining bytes are read.
// - After every write each pointer advances by bytes written, or returns to zero at its end.
// - After an abort the source pointer may lag the reads done.
// - Address error sets flag bit 0 and clears the channel enable.
// - Address error leaves pointers and other status untouched.
// - Address error enable at interrupt register bit 16.
// - Abort source match with event bit 3 sets flag 1; enable 17.
// - Block complete sets flag 3; enable bit 19.
// - Cell complete sets flag 2; enable bit 18.
// - Source end sets flag 7; enable bit 23.
// - Source midpoint sets flag 6; enable bit 22.
// - Destination end sets flag 5; enable bit 21.
// - Destination midpoint sets flag 4; enable bit 20.
// - Enabled flags of a channel OR into one request line.
// - No new transaction is granted while the device sleeps; a running one completes.
// - Only enabled channels (control bit 7) are arbitrated.
// - A start event moves one cell of the 16-bit cell size.
// - Block done at larger size: channel halts, disables, pointers reset.
`timescale 1ns/1ps
`include "dmaarb_defines.svh"
module dmaarb_top #(
  parameter int NCH = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             m_req_o,
  output logic             m_we_o,
  output logic      [31:0] m_addr_o,
  output logic      [3:0]  m_sel_o,
  output logic      [31:0] m_wdata_o,
  input  wire logic [31:0] m_rdata_i,
  input  wire logic        m_ack_i,
  input  wire logic        m_err_i,
  input  wire logic [7:0]  start_i,
  input  wire logic        sys_irq_valid_i,
  input  wire logic [7:0]  sys_irq_num_i,
  input  wire logic        sleep_i,
  output logic      [7:0]  chan_irq_o,
  output logic      [7:0]  cell_done_o,
  output logic      [7:0]  block_done_o
);

  // Channel state; cell pointer, block count and cell-active flag are not software-visible
  logic        on_q     [NCH];
  logic [1:0]  prio_q   [NCH];
  logic        abt_en_q [NCH];
  logic [7:0]  abt_sel_q[NCH];
  logic [7:0]  ien_q    [NCH];
  logic [7:0]  flag_q   [NCH];
  logic [31:0] ssa_q    [NCH];
  logic [31:0] dsa_q    [NCH];
  logic [15:0] ssiz_q   [NCH];
  logic [15:0] dsiz_q   [NCH];
  logic [15:0] csiz_q   [NCH];
  logic [15:0] sptr_q   [NCH];
  logic [15:0] dptr_q   [NCH];
  logic [15:0] cptr_q   [NCH];
  logic [16:0] bcnt_q   [NCH];
  logic        cact_q   [NCH];

  // Engine state
  dmaarb_pkg::dmaarb_state_t st_q;
  logic [2:0]  gnt_q;
  logic [1:0]  lvl_q;
  logic [2:0]  n_q;
  logic [1:0]  soff_q;
  logic [1:0]  doff_q;
  logic [31:0] daddr_q;
  logic [2:0]  rr_q [4];
  logic        m_req_q;
  logic        m_we_q;
  logic [31:0] m_addr_q;
  logic [3:0]  m_sel_q;
  logic [31:0] m_wdata_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [7:0]  irq_q;
  logic [7:0]  cdone_q;
  logic [7:0]  bdone_q;

  // Bus slave decode
  logic        acc;
  logic        wr_en;
  logic        mapped;
  logic [2:0]  rch;
  logic [2:0]  rg;
  logic [31:0] wmask;
  logic [31:0] rd_mux;

  assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign mapped = (wb_adr_i[31:8] == 24'h000000);
  assign wr_en  = acc & wb_we_i & mapped;
  assign rch    = wb_adr_i[7:5];
  assign rg     = wb_adr_i[4:2];
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic [3:0] lanes(input logic [2:0] n, input logic [1:0] off);
    logic [7:0] m;
    m = ((8'h01 << n) - 8'h01) << off;
    lanes = m[3:0];
  endfunction : lanes

  // Arbitration
  logic [NCH-1:0] pend;
  logic [NCH-1:0] cand;
  logic [1:0]     top;
  logic [2:0]     pick;
  logic           found;
  logic [2:0]     idx;

  always_comb begin
    top   = 2'h0;
    pick  = 3'h0;
    found = 1'b0;
    idx   = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      pend[c] = on_q[c] & cact_q[c] & (ssiz_q[c] != 16'h0000)
                & (dsiz_q[c] != 16'h0000) & (csiz_q[c] != 16'h0000);
    end
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < NCH; c++) begin
        if (pend[c] && prio_q[c] == 2'(l)) top = 2'(l);
      end
    end
    for (int c = 0; c < NCH; c++) begin
      cand[c] = pend[c] & (prio_q[c] == top);
    end
    // Scan starts after last winner; reset pointer 7 favours channel 0
    for (int i = 1; i <= NCH; i++) begin
      idx = rr_q[top] + 3'(i);
      if (cand[idx] && !found) begin
        pick  = idx;
        found = 1'b1;
      end
    end
  end

  // Transaction sizing for the candidate channel
  logic [31:0] sa;
  logic [31:0] da;
  logic [15:0] srem;
  logic [15:0] drem;
  logic [15:0] crem;
  logic [2:0]  rd_n;
  logic [2:0]  wr_n;
  logic [2:0]  dl;

  always_comb begin
    sa   = ssa_q[pick] + {16'h0000, sptr_q[pick]};
    da   = dsa_q[pick] + {16'h0000, dptr_q[pick]};
    srem = ssiz_q[pick] - sptr_q[pick];
    drem = dsiz_q[pick] - dptr_q[pick];
    crem = csiz_q[pick] - cptr_q[pick];
    rd_n = 3'h4 - {1'b0, sa[1:0]};
    if (srem < 16'(rd_n)) rd_n = srem[2:0];
    dl   = 3'h4 - {1'b0, da[1:0]};
    wr_n = rd_n;
    if (dl < wr_n) wr_n = dl;
    if (drem < 16'(wr_n)) wr_n = drem[2:0];
    if (crem < 16'(wr_n)) wr_n = crem[2:0];
  end

  // Completion events of the granted channel
  logic        rd_ack;
  logic        wdone;
  logic        aerr;
  logic [16:0] snew;
  logic [16:0] dnew;
  logic [16:0] cnew;
  logic [16:0] bnew;
  logic [16:0] bmax;
  logic        s_end;
  logic        d_end;
  logic        s_half;
  logic        d_half;
  logic        c_end;
  logic        b_end;
  logic [7:0]  fset [NCH];
  logic [NCH-1:0] abt;
  logic [NCH-1:0] hw_off;

  assign rd_ack = (st_q == dmaarb_pkg::ST_RD) & m_ack_i;
  assign wdone  = (st_q == dmaarb_pkg::ST_WR) & m_ack_i;
  assign aerr   = (st_q != dmaarb_pkg::ST_IDLE) & m_err_i;

  always_comb begin
    snew   = {1'b0, sptr_q[gnt_q]} + {14'h0000, n_q};
    dnew   = {1'b0, dptr_q[gnt_q]} + {14'h0000, n_q};
    cnew   = {1'b0, cptr_q[gnt_q]} + {14'h0000, n_q};
    bnew   = bcnt_q[gnt_q] + {14'h0000, n_q};
    bmax   = (ssiz_q[gnt_q] > dsiz_q[gnt_q]) ? {1'b0, ssiz_q[gnt_q]}
                                             : {1'b0, dsiz_q[gnt_q]};
    s_end  = snew >= {1'b0, ssiz_q[gnt_q]};
    d_end  = dnew >= {1'b0, dsiz_q[gnt_q]};
    s_half = (sptr_q[gnt_q] < {1'b0, ssiz_q[gnt_q][15:1]})
             & (snew >= {2'b00, ssiz_q[gnt_q][15:1]});
    d_half = (dptr_q[gnt_q] < {1'b0, dsiz_q[gnt_q][15:1]})
             & (dnew >= {2'b00, dsiz_q[gnt_q][15:1]});
    c_end  = cnew >= {1'b0, csiz_q[gnt_q]};
    b_end  = bnew >= bmax;
    for (int c = 0; c < NCH; c++) begin
      fset[c] = 8'h00;
      abt[c]  = sys_irq_valid_i & abt_en_q[c] & on_q[c]
                & (sys_irq_num_i == abt_sel_q[c]);
      if (abt[c]) fset[c][`DMAARB_F_ABORT] = 1'b1;
      hw_off[c] = abt[c];
      if (gnt_q == 3'(c)) begin
        if (aerr) begin
          fset[c][`DMAARB_F_ERR] = 1'b1;
          hw_off[c] = 1'b1;
        end
        if (wdone) begin
          fset[c][`DMAARB_F_SEND]  = s_end;
          fset[c][`DMAARB_F_SHALF] = s_half;
          fset[c][`DMAARB_F_DEND]  = d_end;
          fset[c][`DMAARB_F_DHALF] = d_half;
          fset[c][`DMAARB_F_CELL]  = c_end | b_end;
          fset[c][`DMAARB_F_BLOCK] = b_end;
          if (b_end) hw_off[c] = 1'b1;
        end
      end
    end
  end

  // Configuration registers; hardware disable overrides a same-cycle write
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        on_q[c]      <= 1'b0;
        prio_q[c]    <= 2'h0;
        abt_en_q[c]  <= 1'b0;
        abt_sel_q[c] <= 8'h00;
        ien_q[c]     <= 8'h00;
        ssa_q[c]     <= 32'h00000000;
        dsa_q[c]     <= 32'h00000000;
        ssiz_q[c]    <= 16'h0000;
        dsiz_q[c]    <= 16'h0000;
        csiz_q[c]    <= 16'h0000;
      end else begin
        if (wr_en && rch == 3'(c)) begin
          unique case (rg)
            `DMAARB_REG_CTRL: begin
              if (wb_sel_i[0]) begin
                on_q[c]   <= wb_dat_i[`DMAARB_CTRL_ON];
                prio_q[c] <= wb_dat_i[1:0];
              end
            end
            `DMAARB_REG_ECON: begin
              if (wb_sel_i[0]) abt_en_q[c] <= wb_dat_i[`DMAARB_ECON_ABT_EN];
              if (wb_sel_i[2]) abt_sel_q[c] <= wb_dat_i[23:16];
            end
            `DMAARB_REG_IRQ: begin
              if (wb_sel_i[2]) ien_q[c] <= wb_dat_i[23:16];
            end
            `DMAARB_REG_SSA: ssa_q[c] <= merge(ssa_q[c], wb_dat_i, wmask);
            `DMAARB_REG_DSA: dsa_q[c] <= merge(dsa_q[c], wb_dat_i, wmask);
            `DMAARB_REG_SIZE: begin
              ssiz_q[c] <= 16'(merge({16'h0000, ssiz_q[c]}, wb_dat_i, wmask));
              dsiz_q[c] <= 16'(merge({16'h0000, dsiz_q[c]},
                                     {16'h0000, wb_dat_i[31:16]},
                                     {16'h0000, wmask[31:16]}));
            end
            `DMAARB_REG_CSIZ: begin
              csiz_q[c] <= 16'(merge({16'h0000, csiz_q[c]}, wb_dat_i, wmask));
            end
            `DMAARB_REG_PTR: ;
          endcase
        end
        if (hw_off[c]) on_q[c] <= 1'b0;
      end
    end
  end

  // Flags: set wins over a same-cycle software clear
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        flag_q[c] <= 8'h00;
      end else if (wr_en && rch == 3'(c) && rg == `DMAARB_REG_IRQ && wb_sel_i[0]) begin
        flag_q[c] <= (flag_q[c] & ~wb_dat_i[7:0]) | fset[c];
      end else begin
        flag_q[c] <= flag_q[c] | fset[c];
      end
    end
  end

  // Pointers and progress counters; an address error touches none
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        sptr_q[c] <= 16'h0000;
        dptr_q[c] <= 16'h0000;
        cptr_q[c] <= 16'h0000;
        bcnt_q[c] <= 17'h00000;
        cact_q[c] <= 1'b0;
      end else begin
        if (start_i[c] && on_q[c]) cact_q[c] <= 1'b1;
        if (abt[c]) cact_q[c] <= 1'b0;
        if (wdone && gnt_q == 3'(c)) begin
          sptr_q[c] <= s_end ? 16'h0000 : snew[15:0];
          dptr_q[c] <= d_end ? 16'h0000 : dnew[15:0];
          cptr_q[c] <= c_end ? 16'h0000 : cnew[15:0];
          bcnt_q[c] <= bnew;
          if (c_end) cact_q[c] <= 1'b0;
          if (b_end) begin
            sptr_q[c] <= 16'h0000;
            dptr_q[c] <= 16'h0000;
            cptr_q[c] <= 16'h0000;
            bcnt_q[c] <= 17'h00000;
            cact_q[c] <= 1'b0;
          end
        end
        // New start address restarts its pointer
        if (wr_en && rch == 3'(c) && rg == `DMAARB_REG_SSA) sptr_q[c] <= 16'h0000;
        if (wr_en && rch == 3'(c) && rg == `DMAARB_REG_DSA) dptr_q[c] <= 16'h0000;
      end
    end
  end

  // Transaction engine: grants only from idle, so a running one is never split
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= dmaarb_pkg::ST_IDLE;
      gnt_q     <= 3'h0;
      lvl_q     <= 2'h0;
      n_q       <= 3'h0;
      soff_q    <= 2'h0;
      doff_q    <= 2'h0;
      daddr_q   <= 32'h00000000;
      m_req_q   <= 1'b0;
      m_we_q    <= 1'b0;
      m_addr_q  <= 32'h00000000;
      m_sel_q   <= 4'h0;
      m_wdata_q <= 32'h00000000;
      for (int l = 0; l < 4; l++) rr_q[l] <= `DMAARB_RR_RESET;
    end else begin
      unique case (st_q)
        dmaarb_pkg::ST_IDLE: begin
          if (found && !sleep_i) begin
            st_q     <= dmaarb_pkg::ST_RD;
            gnt_q    <= pick;
            lvl_q    <= top;
            n_q      <= wr_n;
            soff_q   <= sa[1:0];
            doff_q   <= da[1:0];
            daddr_q  <= {da[31:2], 2'b00};
            m_req_q  <= 1'b1;
            m_we_q   <= 1'b0;
            m_addr_q <= {sa[31:2], 2'b00};
            m_sel_q  <= lanes(rd_n, sa[1:0]);
          end
        end
        dmaarb_pkg::ST_RD: begin
          if (aerr) begin
            st_q    <= dmaarb_pkg::ST_IDLE;
            m_req_q <= 1'b0;
          end else if (rd_ack) begin
            st_q      <= dmaarb_pkg::ST_WR;
            m_we_q    <= 1'b1;
            m_addr_q  <= daddr_q;
            m_sel_q   <= lanes(n_q, doff_q);
            m_wdata_q <= (m_rdata_i >> {soff_q, 3'b000}) << {doff_q, 3'b000};
          end
        end
        dmaarb_pkg::ST_WR: begin
          if (aerr || wdone) begin
            st_q    <= dmaarb_pkg::ST_IDLE;
            m_req_q <= 1'b0;
            m_we_q  <= 1'b0;
          end
          if (wdone) rr_q[lvl_q] <= gnt_q;
        end
        default: st_q <= dmaarb_pkg::ST_IDLE;
      endcase
    end
  end

  // Register read data
  always_comb begin
    rd_mux = 32'h00000000;
    if (mapped) begin
      unique case (rg)
        `DMAARB_REG_CTRL: begin
          rd_mux[`DMAARB_CTRL_ON]   = on_q[rch];
          rd_mux[1:0]               = prio_q[rch];
          rd_mux[`DMAARB_CTRL_BUSY] = (st_q != dmaarb_pkg::ST_IDLE) & (gnt_q == rch);
        end
        `DMAARB_REG_ECON: begin
          rd_mux[`DMAARB_ECON_ABT_EN] = abt_en_q[rch];
          rd_mux[23:16]               = abt_sel_q[rch];
        end
        `DMAARB_REG_IRQ:  rd_mux = {8'h00, ien_q[rch], 8'h00, flag_q[rch]};
        `DMAARB_REG_SSA:  rd_mux = ssa_q[rch];
        `DMAARB_REG_DSA:  rd_mux = dsa_q[rch];
        `DMAARB_REG_SIZE: rd_mux = {dsiz_q[rch], ssiz_q[rch]};
        `DMAARB_REG_CSIZ: rd_mux = {16'h0000, csiz_q[rch]};
        `DMAARB_REG_PTR:  rd_mux = {dptr_q[rch], sptr_q[rch]};
      endcase
    end
  end

  // Slave answers every access one cycle later; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= acc;
      rdat_q <= (acc && !wb_we_i) ? rd_mux : 32'h00000000;
    end
  end

  // Per-channel requests and pulses toward neighbouring logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q   <= 8'h00;
      cdone_q <= 8'h00;
      bdone_q <= 8'h00;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        irq_q[c]   <= |(flag_q[c] & ien_q[c]);
        cdone_q[c] <= fset[c][`DMAARB_F_CELL];
        bdone_q[c] <= fset[c][`DMAARB_F_BLOCK];
      end
    end
  end

  assign wb_dat_o     = rdat_q;
  assign wb_ack_o     = ack_q;
  assign m_req_o      = m_req_q;
  assign m_we_o       = m_we_q;
  assign m_addr_o     = m_addr_q;
  assign m_sel_o      = m_sel_q;
  assign m_wdata_o    = m_wdata_q;
  assign chan_irq_o   = irq_q;
  assign cell_done_o  = cdone_q;
  assign block_done_o = bdone_q;

endmodule : dmaarb_top

// ===== test/dmaarb_assertions.sv
// Port-level timing checks for the channel arbiter
`timescale 1ns/1ps
module dmaarb_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        m_req_o,
  input wire logic        m_we_o,
  input wire logic [31:0] m_addr_o,
  input wire logic [3:0]  m_sel_o,
  input wire logic        m_ack_i,
  input wire logic        m_err_i,
  input wire logic        sleep_i,
  input wire logic [7:0]  cell_done_o,
  input wire logic [7:0]  block_done_o
);
  logic wack_q;
  logic wack2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wack_q  <= 1'b0;
      wack2_q <= 1'b0;
    end else begin
      wack_q  <= m_req_o & m_we_o & m_ack_i;
      wack2_q <= wack_q;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("register ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("register ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack cycle");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[31:8] != 24'h0 |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_req_hold;
    m_req_o && !m_ack_i && !m_err_i |=>
      m_req_o && $stable(m_addr_o) && $stable(m_we_o) && $stable(m_sel_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request changed early");
  property p_rd_wr; m_req_o && !m_we_o && m_ack_i |=> m_req_o && m_we_o; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
  property p_gap; m_req_o && (m_we_o && m_ack_i || m_err_i) |=> !m_req_o; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle");
  property p_sleep; sleep_i [*3] ##0 !m_req_o |=> !m_req_o; endproperty
  a_sleep: assert property (p_sleep) else $error("bus request during sleep");
  property p_cell; |cell_done_o |-> wack_q || wack2_q; endproperty
  a_cell: assert property (p_cell) else $error("cell done without a write");
  property p_block; |block_done_o |=> block_done_o == 8'h0; endproperty
  a_block: assert property (p_block) else $error("block done not a pulse");
  property p_sel; m_req_o |-> m_sel_o != 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("bus request with no byte lane");
  c_err: cover property (m_req_o && m_err_i);
  c_block: cover property (|block_done_o);
  c_sleep: cover property (sleep_i [*3]);
endmodule : dmaarb_checker

bind dmaarb_top dmaarb_checker i_chk (.clk_i, .rst_i, .wb_adr_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .m_req_o, .m_we_o, .m_addr_o, .m_sel_o, .m_ack_i, .m_err_i,
  .sleep_i, .cell_done_o, .block_done_o);

// ===== test/dmaarb_slave_model.sv
// System bus slave: patterned memory, bad top region, optional wait states
`timescale 1ns/1ps
module dmaarb_slave_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        slow_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o,
  output logic             err_o,
  output logic      [31:0] last_addr_o,
  output logic      [3:0]  last_sel_o,
  output logic      [31:0] last_data_o
);
  logic [1:0] wait_q;
  logic       go;
  logic       bad;
  // Skip the answer cycle so one request is never acked twice
  assign go  = req_i && !(ack_o || err_o) && (!slow_i || wait_q == 2'h3);
  assign bad = addr_i[31:28] == 4'hF;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q      <= 2'h0;
      ack_o       <= 1'b0;
      err_o       <= 1'b0;
      rdata_o     <= 32'h0;
      last_addr_o <= 32'h0;
      last_sel_o  <= 4'h0;
      last_data_o <= 32'h0;
    end else begin
      ack_o   <= go && !bad;
      err_o   <= go && bad;
      wait_q  <= (go || !req_i || ack_o || err_o) ? 2'h0 : wait_q + 2'h1;
      // Stale read data toggles so a late sample never matches
      rdata_o <= (go && !we_i) ? (addr_i ^ 32'hA5A50F0F) : ~rdata_o;
      if (go && we_i) begin
        last_addr_o <= addr_i;
        last_sel_o  <= sel_i;
        last_data_o <= wdata_i;
      end
    end
  end
endmodule : dmaarb_slave_model

// ===== test/dmaarb_top_bench.sv
// Self-checking bench for the channel arbiter
`timescale 1ns/1ps
`include "dmaarb_defines.svh"
module dmaarb_top_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] adr   = 32'h0;
  logic [31:0] wdat  = 32'h0;
  logic [3:0]  wsel  = 4'h0;
  logic        wwe   = 1'b0;
  logic        wcyc  = 1'b0;
  logic        wstb  = 1'b0;
  logic [16:0] ev    = 17'h00000;
  logic        sleep = 1'b0;
  logic        slow  = 1'b0;
  wire  [31:0] rdat, maddr, mwdata, mrdata, lw_addr, lw_data;
  wire  [3:0]  msel, lw_sel;
  wire         ack, mreq, mwe, mack, merr;
  wire  [7:0]  irq, cdone, bdone;
  wire  [15:0] mon = {irq, bdone};
  int          miscompares = 0;
  int          compares = 0;
  logic [35:0] rd_q [$];

  initial forever #10 clk_i = ~clk_i;

  dmaarb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(wsel), .wb_we_i(wwe), .wb_cyc_i(wcyc), .wb_stb_i(wstb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .m_req_o(mreq), .m_we_o(mwe), .m_addr_o(maddr), .m_sel_o(msel),
    .m_wdata_o(mwdata), .m_rdata_i(mrdata), .m_ack_i(mack), .m_err_i(merr),
    .start_i(ev[7:0]), .sys_irq_valid_i(ev[16]), .sys_irq_num_i(ev[15:8]), .sleep_i(sleep),
    .chan_irq_o(irq), .cell_done_o(cdone), .block_done_o(bdone));
  dmaarb_slave_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe),
    .addr_i(maddr), .sel_i(msel), .wdata_i(mwdata), .slow_i(slow), .rdata_o(mrdata),
    .ack_o(mack), .err_o(merr), .last_addr_o(lw_addr), .last_sel_o(lw_sel),
    .last_data_o(lw_data));

  always @(posedge clk_i) if (mreq && !mwe && mack) rd_q.push_back({msel, maddr});

  function automatic logic [31:0] ra(input logic [2:0] ch, input logic [2:0] r);
    return {24'h0, ch, r, 2'b00};
  endfunction : ra

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    miscompares++;
    tally_and_finish();
  endtask : hang

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : waitc

  task automatic wb(input logic [31:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    wwe  <= w;
    wsel <= s;
    wdat <= d;
    wcyc <= 1'b1;
    wstb <= 1'b1;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    r = rdat;
    wcyc <= 1'b0;
    wstb <= 1'b0;
    if (n >= 50) hang();
  endtask : wb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, 4'hF, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] r;
    wb(a, 1'b0, 4'hF, 32'h0, r);
    chk(nm, 36'(e), 36'(r & m));
  endtask : rdc

  task automatic wait_hi(input int i);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (mon[i] !== 1'b1 && n < 400);
    if (n >= 400) hang();
  endtask : wait_hi

  task automatic wait_rd(input int k);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (rd_q.size() < k && n < 400);
    if (n >= 400) hang();
  endtask : wait_rd

  task automatic pulse(input logic [16:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 17'h00000;
  endtask : pulse

  task automatic prog(input logic [2:0] ch, input logic [31:0] s, input logic [31:0] d,
                      input logic [15:0] sz, input logic [1:0] p);
    wr(ra(ch, `DMAARB_REG_SSA), s);
    wr(ra(ch, `DMAARB_REG_DSA), d);
    wr(ra(ch, `DMAARB_REG_SIZE), {sz, sz});
    wr(ra(ch, `DMAARB_REG_CSIZ), {16'h0, sz});
    wr(ra(ch, `DMAARB_REG_CTRL), {24'h0, 6'h20, p});
  endtask : prog

  task automatic t_regs;
    rdc("irq reset", ra(3, `DMAARB_REG_IRQ), 32'hFFFFFFFF, 32'h0);
    rdc("ctrl reset", ra(3, `DMAARB_REG_CTRL), 32'hFFFFFFFF, 32'h0);
    wr(ra(3, `DMAARB_REG_IRQ), 32'h00FF00FF);
    rdc("irq enables", ra(3, `DMAARB_REG_IRQ), 32'hFFFFFFFF, 32'h00FF0000);
    wr(ra(3, `DMAARB_REG_ECON), 32'h00050008);
    wr(ra(3, `DMAARB_REG_CTRL), 32'h00000080);
    pulse(17'h10500);
    rdc("abort flag", ra(3, `DMAARB_REG_IRQ), 32'h000000FF, 32'h2);
    rdc("abort off", ra(3, `DMAARB_REG_CTRL), 32'h00000080, 32'h0);
    rdc("unmapped", 32'h00000100, 32'hFFFFFFFF, 32'h0);
    wr(ra(3, `DMAARB_REG_IRQ), 32'h0);
    $display("test regs ended");
  endtask : t_regs

  task automatic t_xfer;
    logic [31:0] r;
    rd_q.delete();
    sleep <= 1'b1;
    prog(3'd0, 32'h00001001, 32'h00002000, 16'h0003, 2'd0);
    wr(ra(0, `DMAARB_REG_IRQ), 32'h00080000);
    pulse(17'h00001);
    waitc(20);
    chk("request in sleep", 36'h0, 36'(mreq));
    sleep <= 1'b0;
    wait_hi(0);
    chk("read lanes", {4'hE, 32'h00001000}, rd_q[0]);
    chk("write lanes", {4'h7, 32'h00002000}, {lw_sel, lw_addr});
    chk("write data", 36'h000A5A51F, 36'(lw_data & 32'h00FFFFFF));
    rdc("done flags", ra(0, `DMAARB_REG_IRQ), 32'h000800FC, 32'h000800FC);
    rdc("ctrl enable", ra(0, `DMAARB_REG_CTRL), 32'h00000080, 32'h0);
    rdc("pointers", ra(0, `DMAARB_REG_PTR), 32'hFFFFFFFF, 32'h0);
    chk("irq line", 36'h1, 36'(irq[0]));
    wb(ra(0, `DMAARB_REG_IRQ), 1'b1, 4'h1, 32'h000000FF, r);
    waitc(3);
    chk("irq cleared", 36'h0, 36'(irq[0]));
    $display("test transfer ended");
  endtask : t_xfer

  // Two channels of six bytes each: a full word then a two-byte tail
  task automatic t_prio(input logic [1:0] p0, input logic [1:0] p1,
                        input logic [35:0] e0, input logic [35:0] e1,
                        input logic [35:0] e2, input logic [35:0] e3);
    logic [35:0] e [4];
    e = '{e0, e1, e2, e3};
    rd_q.delete();
    prog(3'd0, 32'h00003000, 32'h00005000, 16'h0006, p0);
    prog(3'd1, 32'h00004000, 32'h00005100, 16'h0006, p1);
    pulse(17'h00003);
    wait_rd(4);
    waitc(10);
    for (int i = 0; i < 4; i++) chk("read order", e[i], rd_q[i]);
    $display("test priority ended");
  endtask : t_prio

  task automatic t_err;
    slow <= 1'b1;
    prog(3'd2, 32'hF0000000, 32'h00006000, 16'h0004, 2'd0);
    wr(ra(2, `DMAARB_REG_IRQ), 32'h00010000);
    pulse(17'h00004);
    wait_hi(10);
    chk("error irq", 36'h1, 36'(irq[2]));
    rdc("error flags", ra(2, `DMAARB_REG_IRQ), 32'h000000FF, 32'h1);
    rdc("error enable", ra(2, `DMAARB_REG_CTRL), 32'h00000080, 32'h0);
    rdc("error pointers", ra(2, `DMAARB_REG_PTR), 32'hFFFFFFFF, 32'h0);
    slow <= 1'b0;
    $display("test error ended");
  endtask : t_err

  initial begin
    waitc(6);
    rst_i <= 1'b0;
    waitc(1);
    t_regs();
    t_xfer();
    t_prio(2'd0, 2'd3, {4'hF, 32'h4000}, {4'h3, 32'h4004},
           {4'hF, 32'h3000}, {4'h3, 32'h3004});
    t_prio(2'd2, 2'd2, {4'hF, 32'h3000}, {4'hF, 32'h4000},
           {4'h3, 32'h3004}, {4'h3, 32'h4004});
    t_err();
    tally_and_finish();
  end
endmodule : dmaarb_top_bench
